// [logic/fsq_latches.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fsq_regs.svh"
module fsq_latches (
   input  wire logic        mclk_i,   // System clock.
   input  wire logic        reset_i,  // Synchronous reset.
   input  wire logic        load_i,   // Load one latch.
   input  wire logic [4:0]  sel_i,    // Latch index.
   input  wire logic [13:0] data_i,   // Word to load.
   input  wire logic        blank_i,  // Return all latches to blank.
   input  wire logic [4:0]  rd_sel_i, // Latch read index.
   output logic      [13:0] rd_o      // Selected latch word.
);
   logic [13:0] latch_q [0:31];

   always_ff @(posedge mclk_i) begin
      for (int i = 0; i < `FSQ_ROW_WORDS; i++) begin
         if (reset_i || blank_i) begin
            latch_q[i] <= `FSQ_LATCH_BLANK;
         end else if (load_i && sel_i == 5'(i)) begin
            latch_q[i] <= data_i;
         end
      end
   end

   assign rd_o = latch_q[rd_sel_i];
endmodule
`default_nettype wire

// [logic/fsq_pkg.sv]
package fsq_pkg;
   typedef enum logic [4:0] {
      FSQ_IDLE    = 5'b00001,
      FSQ_ERASE   = 5'b00010,
      FSQ_PROGRAM = 5'b00100,
      FSQ_WAIT    = 5'b01000,
      FSQ_DONE    = 5'b10000
   } fsq_state_t;
   typedef enum logic [1:0] {
      FSQ_UNL_IDLE = 2'b00,
      FSQ_UNL_KEY1 = 2'b01,
      FSQ_UNL_ARM  = 2'b10
   } fsq_unlock_t;
endpackage

// [logic/fsq_regs.svh]
// Operation
// - Erase or program start on protected address sets write error.
// - Reset during self-write sets write error.
// - Interrupted unlock sequence sets write error.
// - Software may also set write error.
// - Only a software write or reset clears the write error flag.
// - Erase select erases whole 32-word row.
// - Protected erase or program: abort, flag error.
// - Latch-only copies data into one write latch.
// - Program writes latches into addressed flash row.
// - After programming, every latch returns to 3FFh.
`ifndef FSQ_REGS_SVH
`define FSQ_REGS_SVH

`define FSQ_ADR_ADDR_LO   4'h0
`define FSQ_ADR_ADDR_HI   4'h1
`define FSQ_ADR_DATA_LO   4'h2
`define FSQ_ADR_DATA_HI   4'h3
`define FSQ_ADR_CTRL      4'h4
`define FSQ_ADR_UNLOCK    4'h5
`define FSQ_ADR_IRQ_STAT  4'h6
`define FSQ_ADR_IRQ_MASK  4'h7
`define FSQ_ADR_PROT      4'h8

`define FSQ_CTRL_START    0
`define FSQ_CTRL_WREN     1
`define FSQ_CTRL_WERR     2
`define FSQ_CTRL_LATCH    3
`define FSQ_CTRL_ERASE    4
`define FSQ_CTRL_BUSY     5

`define FSQ_IRQ_DONE      0
`define FSQ_IRQ_ERR       1

`define FSQ_UNLOCK_KEY1   8'h55
`define FSQ_UNLOCK_KEY2   8'hAA
`define FSQ_LATCH_RESET   14'h3FFF
`define FSQ_LATCH_BLANK   14'h03FF
`define FSQ_ROW_WORDS     32
`define FSQ_PROT_RESET    15'h0000

`endif

// [logic/fsq_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fsq_regs.svh"
module fsq_sequencer
   import fsq_pkg::*;
(
   input  wire logic        mclk_i,         // 250 MHz system clock.
   input  wire logic        reset_i,        // Synchronous reset, high.
   input  wire logic [3:0]  addr_i,         // Register address.
   input  wire logic [7:0]  wdata_i,        // Register write data.
   input  wire logic        wr_i,           // Register write strobe.
   input  wire logic        rd_i,           // Register read strobe.
   output logic      [7:0]  rdata_o,        // Read data, one cycle later.
   output logic             irq_o,          // Level interrupt.
   output logic      [14:0] fl_addr_o,      // Flash word address.
   output logic      [13:0] fl_wdata_o,     // Flash word to program.
   output logic             fl_erase_o,     // Erase row strobe.
   output logic             fl_prog_o,      // Program word strobe.
   input  wire logic        fl_ready_i,     // Array ready for next step.
   output logic             write_error_flag_o // Sticky write error.
);
   // Control bits.
   logic [7:0]  flash_address_low;
   logic [6:0]  flash_address_high;
   logic [7:0]  flash_data_low;
   logic [5:0]  flash_data_high;
   logic        start;
   logic        wren;
   logic        write_error_flag;
   logic        latch_only_select;
   logic        erase_sel;
   logic [14:0] prot_limit;
   logic [1:0]  irq_stat;
   logic [1:0]  irq_mask;
   logic        sw_err_set;
   logic        wait_pending;

   fsq_state_t  state;
   fsq_unlock_t unl;
   logic [4:0]  word_cnt;
   logic [13:0] latch_word;
   logic        latch_load;
   logic        latch_blank;
   logic        hw_done;
   logic        hw_err;
   logic        unlock_ok;
   logic        unlock_break;
   logic        start_wr;
   logic        protected_hit;
   logic        busy_at_reset;
   logic [14:0] cur_addr;
   logic        mode_latch;
   logic        mode_erase;

   assign cur_addr      = {flash_address_high, flash_address_low};
   assign protected_hit = cur_addr < prot_limit;
   assign start_wr      = wr_i && addr_i == `FSQ_ADR_CTRL
                          && wdata_i[`FSQ_CTRL_START] && !start;
   assign unlock_ok     = unl == FSQ_UNL_ARM;
   // A write to any other register between the keys breaks the sequence.
   assign unlock_break  = unl != FSQ_UNL_IDLE && wr_i
                          && addr_i != `FSQ_ADR_UNLOCK
                          && !(start_wr && unlock_ok);
   assign sw_err_set    = wr_i && addr_i == `FSQ_ADR_CTRL
                          && wdata_i[`FSQ_CTRL_WERR];
   // The start write carries its own mode; the mode registers only take it
   // on the same edge, which is too late for the decision.
   assign mode_latch    = wdata_i[`FSQ_CTRL_LATCH];
   assign mode_erase    = wdata_i[`FSQ_CTRL_ERASE];

   fsq_latches u_latches (
      .mclk_i   (mclk_i),
      .reset_i  (reset_i),
      .load_i   (latch_load),
      .sel_i    (flash_address_low[4:0]),
      .data_i   ({flash_data_high, flash_data_low}),
      .blank_i  (latch_blank),
      .rd_sel_i (word_cnt),
      .rd_o     (latch_word)
   );

   // Address and data registers.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         flash_address_low  <= 8'h00;
         flash_address_high <= 7'h00;
         flash_data_low     <= 8'h00;
         flash_data_high    <= 6'h00;
         prot_limit         <= `FSQ_PROT_RESET;
         wren               <= 1'b0;
      end else if (wr_i) begin
         unique case (addr_i)
            `FSQ_ADR_ADDR_LO: flash_address_low  <= wdata_i;
            `FSQ_ADR_ADDR_HI: flash_address_high <= wdata_i[6:0];
            `FSQ_ADR_DATA_LO: flash_data_low     <= wdata_i;
            `FSQ_ADR_DATA_HI: flash_data_high    <= wdata_i[5:0];
            `FSQ_ADR_CTRL:    wren <= wdata_i[`FSQ_CTRL_WREN];
            `FSQ_ADR_PROT:    prot_limit <= {wdata_i[6:0], 8'h00};
            default: ;
         endcase
      end
   end

   // Mode bits may only change while idle.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         latch_only_select <= 1'b0;
         erase_sel         <= 1'b0;
      end else if (wr_i && addr_i == `FSQ_ADR_CTRL && !start) begin
         latch_only_select <= wdata_i[`FSQ_CTRL_LATCH];
         erase_sel         <= wdata_i[`FSQ_CTRL_ERASE];
      end
   end

   // Unlock sequence: key1 then key2 to the unlock register, then start.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         unl <= FSQ_UNL_IDLE;
      end else if (wr_i && addr_i == `FSQ_ADR_UNLOCK) begin
         if (wdata_i == `FSQ_UNLOCK_KEY1) begin
            unl <= FSQ_UNL_KEY1;
         end else if (wdata_i == `FSQ_UNLOCK_KEY2 && unl == FSQ_UNL_KEY1) begin
            unl <= FSQ_UNL_ARM;
         end else begin
            unl <= FSQ_UNL_IDLE;
         end
      end else if (wr_i) begin
         unl <= FSQ_UNL_IDLE;
      end
   end

   // A reset that lands during a self-write is held through the reset and
   // raises the error flag on the first cycle after release.
   always_ff @(posedge mclk_i) begin
      if (!reset_i) begin
         busy_at_reset <= 1'b0;
      end else if (state inside {FSQ_ERASE, FSQ_PROGRAM, FSQ_WAIT}) begin
         busy_at_reset <= 1'b1;
      end
   end

   // Sequencer.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state        <= FSQ_IDLE;
         start        <= 1'b0;
         word_cnt     <= 5'h00;
         fl_erase_o   <= 1'b0;
         fl_prog_o    <= 1'b0;
         fl_addr_o    <= 15'h0000;
         fl_wdata_o   <= 14'h0000;
         latch_load   <= 1'b0;
         latch_blank  <= 1'b0;
         hw_done      <= 1'b0;
         hw_err       <= 1'b0;
         wait_pending <= 1'b0;
      end else begin
         fl_erase_o  <= 1'b0;
         fl_prog_o   <= 1'b0;
         latch_load  <= 1'b0;
         latch_blank <= 1'b0;
         hw_done     <= 1'b0;
         hw_err      <= 1'b0;
         unique case (state)
            FSQ_IDLE: begin
               if (start_wr && wren && unlock_ok) begin
                  if (mode_latch && !mode_erase) begin
                     latch_load <= 1'b1;
                     start      <= 1'b1;
                     state      <= FSQ_DONE;
                  end else if (protected_hit) begin
                     hw_err <= 1'b1;
                  end else if (mode_erase) begin
                     start      <= 1'b1;
                     fl_addr_o  <= {cur_addr[14:5], 5'h00};
                     fl_erase_o <= 1'b1;
                     state      <= FSQ_ERASE;
                  end else begin
                     start    <= 1'b1;
                     word_cnt <= 5'h00;
                     state    <= FSQ_PROGRAM;
                  end
               end
            end
            FSQ_PROGRAM: begin
               if (fl_ready_i && !fl_prog_o) begin
                  fl_addr_o  <= {cur_addr[14:5], word_cnt};
                  fl_wdata_o <= latch_word;
                  fl_prog_o  <= 1'b1;
                  word_cnt   <= word_cnt + 5'h01;
                  if (word_cnt == 5'h1F) begin
                     state <= FSQ_WAIT;
                  end
               end
            end
            FSQ_ERASE: state <= FSQ_WAIT;
            FSQ_WAIT: begin
               // One idle cycle lets the array drop ready after a strobe.
               wait_pending <= ~wait_pending;
               if (wait_pending && fl_ready_i) begin
                  latch_blank  <= !erase_sel;
                  wait_pending <= 1'b0;
                  state        <= FSQ_DONE;
               end
            end
            FSQ_DONE: begin
               start   <= 1'b0;
               hw_done <= 1'b1;
               state   <= FSQ_IDLE;
            end
            default: state <= FSQ_IDLE;
         endcase
      end
   end

   // Sticky error: hardware and software set, only a zero write or reset clears.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         write_error_flag <= 1'b0;
      end else if (hw_err || unlock_break || busy_at_reset || sw_err_set) begin
         write_error_flag <= 1'b1;
      end else if (wr_i && addr_i == `FSQ_ADR_CTRL) begin
         write_error_flag <= 1'b0;
      end
   end

   // Interrupt status, write one to clear; a new event wins over the clear.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         irq_stat <= 2'h0;
         irq_mask <= 2'h0;
      end else begin
         irq_stat <= (irq_stat
                      & ~((wr_i && addr_i == `FSQ_ADR_IRQ_STAT)
                          ? wdata_i[1:0] : 2'h0))
                     | {hw_err | unlock_break, hw_done};
         if (wr_i && addr_i == `FSQ_ADR_IRQ_MASK) begin
            irq_mask <= wdata_i[1:0];
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         irq_o              <= 1'b0;
         write_error_flag_o <= 1'b0;
      end else begin
         irq_o              <= |(irq_stat & irq_mask);
         write_error_flag_o <= write_error_flag;
      end
   end

   // Read port.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rdata_o <= 8'h00;
      end else if (rd_i) begin
         unique case (addr_i)
            `FSQ_ADR_ADDR_LO:  rdata_o <= flash_address_low;
            `FSQ_ADR_ADDR_HI:  rdata_o <= {1'b0, flash_address_high};
            `FSQ_ADR_DATA_LO:  rdata_o <= flash_data_low;
            `FSQ_ADR_DATA_HI:  rdata_o <= {2'b00, flash_data_high};
            `FSQ_ADR_CTRL:     rdata_o <= {2'b00, start, erase_sel,
                                  latch_only_select, write_error_flag,
                                  wren, start};
            `FSQ_ADR_IRQ_STAT: rdata_o <= {6'h00, irq_stat};
            `FSQ_ADR_IRQ_MASK: rdata_o <= {6'h00, irq_mask};
            `FSQ_ADR_PROT:     rdata_o <= {1'b0, prot_limit[14:8]};
            default:           rdata_o <= 8'h00;
         endcase
      end else begin
         rdata_o <= 8'h00;
      end
   end
endmodule
`default_nettype wire

// [sim/flash_row_write_erase_sequencer_tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fsq_regs.svh"
module flash_row_write_erase_sequencer_tb;
   localparam logic [13:0] ERASED = 14'h3FFF;
   logic        mclk_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic        slow = 1'b0;
   logic [3:0]  addr_i = 4'h0;
   logic [7:0]  wdata_i = 8'h00;
   logic [7:0]  rdata_o, got;
   logic        irq_o, fl_erase_o, fl_prog_o, fl_ready_i, werr;
   logic [14:0] fl_addr_o;
   logic [13:0] fl_wdata_o, e;
   logic [13:0] exp_w [32];
   logic [9:0]  row;
   int          failures = 0, tests_run = 0, pulses = 0, base;
   fsq_sequencer fsq_sequencer_inst (.mclk_i(mclk_i), .reset_i(reset_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .irq_o(irq_o), .fl_addr_o(fl_addr_o),
      .fl_wdata_o(fl_wdata_o), .fl_erase_o(fl_erase_o),
      .fl_prog_o(fl_prog_o), .fl_ready_i(fl_ready_i),
      .write_error_flag_o(werr));
   fsq_flash_model #(.ERASED(ERASED)) fsq_flash_model_inst (.mclk_i(mclk_i),
      .reset_i(reset_i), .addr_i(fl_addr_o), .wdata_i(fl_wdata_o),
      .erase_i(fl_erase_o), .prog_i(fl_prog_o), .slow_i(slow),
      .ready_o(fl_ready_i));
   always #2 mclk_i = ~mclk_i;
   always @(posedge mclk_i) if (fl_erase_o || fl_prog_o) pulses++;
   function automatic int key(input logic [9:0] r, input int w);
      return int'({r, 5'(w)});
   endfunction
   task automatic chk(input logic [15:0] g, input logic [15:0] x);
      tests_run++;
      if (g !== x) begin
         failures++;
         $display("unexpected at %0t: got %h exp %h", $time, g, x);
      end
   endtask
   task automatic settle;
      repeat (3) @(posedge mclk_i);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge mclk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge mclk_i);
      rd_i <= 1'b0;
      #1 got = rdata_o;
   endtask
   task automatic ld(input logic [9:0] r, input logic [4:0] w,
                     input logic [13:0] d);
      wr(`FSQ_ADR_ADDR_LO, {r[2:0], w});
      wr(`FSQ_ADR_ADDR_HI, {1'b0, r[9:3]});
      wr(`FSQ_ADR_DATA_LO, d[7:0]);
      wr(`FSQ_ADR_DATA_HI, {2'b00, d[13:8]});
   endtask
   task automatic arm(input logic [7:0] c);
      wr(`FSQ_ADR_UNLOCK, `FSQ_UNLOCK_KEY1);
      wr(`FSQ_ADR_UNLOCK, `FSQ_UNLOCK_KEY2);
      wr(`FSQ_ADR_CTRL, c);
   endtask
   task automatic go(input logic [7:0] c);
      arm(c);
      settle;
      for (int n = 0; n < 200; n++) begin
         rd(`FSQ_ADR_CTRL);
         if ((got & 8'h21) === 8'h00) break;
      end
      chk(16'(got & 8'h21), 16'h0000);
      settle;
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      report_and_stop;
   end
   initial begin
      void'($urandom(32'hd441));
      repeat (12) @(posedge mclk_i);
      reset_i <= 1'b0;
      rd(`FSQ_ADR_CTRL);
      chk(16'(got), 16'h0000);
      rd(4'hF);
      chk(16'(got), 16'h0000);
      // The start write checks the enable as it stood before that write.
      wr(`FSQ_ADR_CTRL, 8'h02);
      row = 10'h040 + 10'($urandom % 384);
      for (int w = 0; w < 32; w++) begin
         exp_w[w] = 14'($urandom);
         ld(row, 5'(w), exp_w[w]);
         go(8'h0B);
      end
      chk(16'(pulses), 16'h0000);
      for (int p = 0; p < 2; p++) begin
         slow = p[0];
         ld(row + 10'(p), 5'($urandom), 14'($urandom));
         go(8'h03);
         for (int w = 0; w < 32; w++) begin
            e = p ? `FSQ_LATCH_BLANK : exp_w[w];
            base = key(row + 10'(p), w);
            chk(16'(fsq_flash_model_inst.mem[base]), 16'(e));
         end
      end
      ld(row, 5'($urandom), 14'($urandom));
      go(8'h1B);
      for (int w = 0; w < 32; w++) begin
         base = key(row, w);
         chk(16'(fsq_flash_model_inst.mem[base]), 16'(ERASED));
      end
      base = key(row + 10'h001, 0);
      e = `FSQ_LATCH_BLANK;
      chk(16'(fsq_flash_model_inst.mem[base]), 16'(e));
      base = pulses;
      wr(`FSQ_ADR_PROT, 8'h01);
      ld(10'h003, 5'h00, 14'h0000);
      go(8'h13);
      chk(16'(got & 8'h05), 16'h0004);
      chk(16'(werr), 16'h0001);
      chk(16'(irq_o), 16'h0000);
      wr(`FSQ_ADR_IRQ_MASK, 8'h02);
      settle;
      chk(16'(irq_o), 16'h0001);
      wr(`FSQ_ADR_IRQ_STAT, 8'h02);
      settle;
      chk(16'(irq_o), 16'h0000);
      go(8'h03);
      chk(16'(pulses - base), 16'h0000);
      chk(16'(werr), 16'h0001);
      for (int k = 0; k < 2; k++) begin
         wr(`FSQ_ADR_CTRL, 8'h00);
         settle;
         chk(16'(werr), 16'h0000);
         if (k == 0) begin
            wr(`FSQ_ADR_CTRL, 8'h04);
         end else begin
            wr(`FSQ_ADR_UNLOCK, `FSQ_UNLOCK_KEY1);
            wr(`FSQ_ADR_ADDR_LO, 8'h00);
         end
         settle;
         chk(16'(werr), 16'h0001);
      end
      // Clear the flag and leave the write enable set for the next start.
      wr(`FSQ_ADR_CTRL, 8'h02);
      wr(`FSQ_ADR_PROT, 8'h00);
      slow = 1'b1;
      ld(row, 5'h00, 14'h0000);
      arm(8'h03);
      for (int n = 0; n < 50 && !fl_prog_o; n++) @(posedge mclk_i) #1;
      @(posedge mclk_i);
      reset_i <= 1'b1;
      repeat (3) @(posedge mclk_i);
      reset_i <= 1'b0;
      settle;
      chk(16'(werr), 16'h0001);
      report_and_stop;
   end
endmodule
`default_nettype wire

// [sim/fsq_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
module fsq_flash_model #(
   parameter logic [13:0] ERASED = 14'h3FFF
) (
   input  wire logic        mclk_i,  // Clock.
   input  wire logic        reset_i, // Reset.
   input  wire logic [14:0] addr_i,  // Word address.
   input  wire logic [13:0] wdata_i, // Word to store.
   input  wire logic        erase_i, // Erase row.
   input  wire logic        prog_i,  // Program word.
   input  wire logic        slow_i,  // Stretch busy time.
   output logic             ready_o  // Array ready.
);
   logic [13:0] mem [int];
   logic [2:0]  busy;
   assign ready_o = busy == 3'h0;
   // A slow array keeps ready low so the sequencer really has to wait.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         busy <= 3'h0;
      end else if (erase_i || prog_i) begin
         busy <= slow_i ? 3'h5 : 3'h0;
      end else if (busy != 3'h0) begin
         busy <= busy - 3'h1;
      end
   end
   always @(posedge mclk_i) begin
      if (!reset_i && erase_i) begin
         for (int i = 0; i < 32; i++) begin
            mem[{addr_i[14:5], 5'(i)}] = ERASED;
         end
      end
      if (!reset_i && prog_i) begin
         mem[addr_i] = wdata_i;
      end
   end
endmodule
`default_nettype wire

// [sim/fsq_props.sv]
`timescale 1ns/1ps
`default_nettype none
module fsq_props (
   input wire logic        mclk_i,             // Clock.
   input wire logic        reset_i,            // Reset.
   input wire logic [3:0]  addr_i,             // Address.
   input wire logic [7:0]  wdata_i,            // Data.
   input wire logic        wr_i,               // Write.
   input wire logic        rd_i,               // Read.
   input wire logic [7:0]  rdata_o,            // Read data.
   input wire logic        irq_o,              // Interrupt.
   input wire logic [14:0] fl_addr_o,          // Flash address.
   input wire logic [13:0] fl_wdata_o,         // Flash word.
   input wire logic        fl_erase_o,         // Erase.
   input wire logic        fl_prog_o,          // Program.
   input wire logic        fl_ready_i,         // Ready.
   input wire logic        write_error_flag_o  // Error flag.
);
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (reset_i);
   sequence s_two_prog;
      fl_prog_o ##2 fl_prog_o;
   endsequence
   sequence s_quiet;
      (!fl_erase_o && !fl_prog_o) [*2];
   endsequence
   // The flag copy trails the register by one cycle, hence depth two.
   a_err_sticky: assert property ($fell(write_error_flag_o)
      |-> $past(wr_i && addr_i == 4'h4 && !wdata_i[2], 2))
      else $error("error flag fell without a clearing write");
   a_err_soft_set: assert property (wr_i && addr_i == 4'h4
      && wdata_i[2] |-> ##2 write_error_flag_o)
      else $error("software could not set the error flag");
   a_erase_once: assert property (fl_erase_o |=> s_quiet)
      else $error("erase strobe repeated");
   a_erase_row: assert property (fl_erase_o
      |-> fl_addr_o[4:0] == 5'h00)
      else $error("erase address not row aligned");
   a_prog_gap: assert property (fl_prog_o |=> !fl_prog_o)
      else $error("program strobes too close");
   a_prog_ready: assert property (fl_prog_o
      |-> $past(fl_ready_i))
      else $error("program strobe while array busy");
   a_prog_step: assert property (s_two_prog
      |-> fl_addr_o == $past(fl_addr_o, 2) + 15'h0001)
      else $error("program address did not advance by one");
   a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
      else $error("read data outside its cycle");
   a_irq_drop: assert property ($fell(irq_o) |-> $past(wr_i, 2))
      else $error("interrupt fell without a write");
endmodule
bind fsq_sequencer fsq_props fsq_props_inst (.mclk_i, .reset_i, .addr_i,
   .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_o, .fl_addr_o, .fl_wdata_o,
   .fl_erase_o, .fl_prog_o, .fl_ready_i, .write_error_flag_o);
`default_nettype wire
